// File: hw/addr_decoder.sv
`default_nettype none
module addr_decoder (
   // Request and mode
   input  wire pmode_pkg::bus_req_t   i_req,
   input  wire pmode_pkg::proc_mode_t i_mode,
   input  wire logic                  i_rom_lock,
   // Result
   output pmode_pkg::decode_t         o_dec
);

   function automatic pmode_pkg::region_t map_addr(
      input logic [31:0]          a,
      input pmode_pkg::proc_mode_t m,
      input logic                 lock);
      pmode_pkg::region_t r;
      logic               ext;
      r   = pmode_pkg::REG_NONE;
      ext = (m == pmode_pkg::MODE_EXPAND) || (m == pmode_pkg::MODE_MICRO);
      if (a < pmode_pkg::ADDR_RAM)
         r = pmode_pkg::REG_PERIPH;
      else if (a < pmode_pkg::ADDR_PERIPH2)
         r = pmode_pkg::REG_RAM;
      else if (a < pmode_pkg::ADDR_RSVD1)
         r = pmode_pkg::REG_PERIPH2;
      else if (a < pmode_pkg::ADDR_DROM)
         r = pmode_pkg::REG_NONE;
      else if (a < pmode_pkg::ADDR_DROM_END)
         r = pmode_pkg::REG_DATA_ROM;
      else if (a < pmode_pkg::ADDR_EXT_LO)
         r = pmode_pkg::REG_NONE;
      else if (a < pmode_pkg::ADDR_UNUSABLE)
         r = ext ? pmode_pkg::REG_EXTERNAL : pmode_pkg::REG_NONE;
      else if (a < pmode_pkg::ADDR_EXT_HI)
         r = pmode_pkg::REG_UNUSABLE;
      else if (a < pmode_pkg::ADDR_TOP_ROM)
         r = (m == pmode_pkg::MODE_EXPAND) ? pmode_pkg::REG_EXTERNAL
                                            : pmode_pkg::REG_NONE;
      else if (m == pmode_pkg::MODE_MICRO)
         r = pmode_pkg::REG_EXTERNAL;
      else
         r = lock ? pmode_pkg::REG_NONE : pmode_pkg::REG_INT_ROM;
      return r;
   endfunction : map_addr

   always_comb begin
      o_dec.region = map_addr(i_req.addr, i_mode, i_rom_lock);
      o_dec.hit    = i_req.valid &&
                     (o_dec.region != pmode_pkg::REG_NONE) &&
                     (o_dec.region != pmode_pkg::REG_UNUSABLE);
   end

endmodule : addr_decoder
`default_nettype wire

// File: hw/pmode_pkg.sv
`default_nettype none
package pmode_pkg;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_EXPAND = 2'b01,
      MODE_RSVD   = 2'b10,
      MODE_MICRO  = 2'b11
   } proc_mode_t;

   typedef enum logic [2:0] {
      REG_NONE, REG_PERIPH, REG_RAM, REG_PERIPH2, REG_DATA_ROM,
      REG_INT_ROM, REG_EXTERNAL, REG_UNUSABLE
   } region_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } bus_req_t;

   typedef struct packed {
      region_t     region;
      logic        hit;
   } decode_t;

   localparam logic [31:0] ADDR_RAM       = 32'h0000_0400;
   localparam logic [31:0] ADDR_PERIPH2   = 32'h0004_0000;
   localparam logic [31:0] ADDR_RSVD1     = 32'h0005_0000;
   localparam logic [31:0] ADDR_DROM      = 32'h0006_0000;
   localparam logic [31:0] ADDR_DROM_END  = 32'h0006_2000;
   localparam logic [31:0] ADDR_EXT_LO    = 32'h0008_0000;
   localparam logic [31:0] ADDR_UNUSABLE  = 32'h0200_0000;
   localparam logic [31:0] ADDR_EXT_HI    = 32'hfe00_0000;
   localparam logic [31:0] ADDR_TOP_ROM   = 32'hffe0_0000;

   localparam int          MODE_LSB       = 0;
   localparam int          SWRST_BIT      = 3;
   localparam int          BCLK_SEL_BIT   = 7;
   localparam logic [7:0]  PM_RESET       = 8'h00;
   localparam logic [1:0]  CLKPIN_PORT    = 2'b00;
   localparam logic [1:0]  WIDTH_MASK     = 2'b11;

endpackage : pmode_pkg
`default_nettype wire

// File: hw/processor_mode_select.sv
// Functional notes
// - Hardware reset starts single-chip if boot pin low, microprocessor if high.
// - Writing 01b to the mode field enters memory-expansion mode.
// - After a microprocessor-mode start, internal ROM stays inaccessible until a hardware reset with boot pin low.
// - Mode register writes need the write enable bit set, else ignored.
// - Software reset bit resets the device but keeps the processor mode.
// - Single-chip mode never drives the bus clock out.
// - Bus modes, select bit 1, pin function 00b: clock pin drives low.
// - 00080000h-02000000h is external in bus modes, never in single-chip.
// - 02000000h up to FE000000h is unusable in every mode.
// - Top range from FFE00000h external in microprocessor, else internal ROM unless locked.
// - Peripherals at zero, RAM from 00000400h, data ROM 00060000h-00062000h.
// - Bus modes give pins to bus control; single-chip keeps all as ports.
// - Microprocessor mode reaches peripherals, internal RAM and external space.
// - Watchdog reset resets the device but keeps the processor mode.
// - Micro mode: vector low bits pick bus width; start address low bits 00b.
`default_nettype none
module processor_mode_select (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_reset,
   // Straps and reset sources
   input  wire logic                  i_boot_mode_pin,
   input  wire logic                  i_watchdog_reset,
   // Register write port
   input  wire logic                  i_pm_write,
   input  wire logic [7:0]            i_pm_wdata,
   input  wire logic                  i_mode_register_write_enable,
   // Clock mode register pin function
   input  wire logic [1:0]            i_clock_pin_function,
   input  wire logic                  i_bus_clock,
   // Reset vector fetch
   input  wire logic                  i_vector_valid,
   input  wire logic [31:0]           i_reset_vector,
   // Address decode request
   input  wire pmode_pkg::bus_req_t   i_req,
   // Register and status
   output logic [7:0]                 o_processor_mode_register,
   output pmode_pkg::proc_mode_t      o_mode,
   output logic                       o_rom_lock,
   output logic                       o_device_reset,
   // Pins
   output logic                       o_bus_pins_enable,
   output logic                       o_clock_pin_port,
   output logic                       o_clock_pin_port_oe,
   // Boot
   output logic [31:0]                o_start_addr,
   output logic [1:0]                 o_ext_bus_width,
   // Decode result
   output pmode_pkg::decode_t         o_dec
);

   logic [7:0]            pm_reg, pm_next;
   logic                  lock_reg, lock_next;
   logic                  boot_reg, boot_next;
   logic                  rst_reg, rst_next;
   logic                  busen_reg, busen_next;
   logic                  clk_reg, clk_next;
   logic                  clkoe_reg, clkoe_next;
   logic [31:0]           start_reg, start_next;
   logic [1:0]            width_reg, width_next;
   pmode_pkg::decode_t    dec_reg, dec_next;
   pmode_pkg::proc_mode_t mode_now;
   logic                  soft_rst;
   logic                  bus_mode;

   assign mode_now = pmode_pkg::proc_mode_t'(pm_reg[1:0]);
   assign bus_mode = (mode_now == pmode_pkg::MODE_EXPAND) ||
                     (mode_now == pmode_pkg::MODE_MICRO);
   assign soft_rst = rst_reg;

   addr_decoder u_dec (
      .i_req      (i_req),
      .i_mode     (mode_now),
      .i_rom_lock (lock_reg),
      .o_dec      (dec_next)
   );

   // Mode register state
   always_comb begin
      pm_next   = pm_reg;
      lock_next = lock_reg;
      boot_next = 1'b0;
      rst_next  = 1'b0;
      if (boot_reg) begin
         // First cycle after hardware reset release: catch the strap
         pm_next[1:0] = i_boot_mode_pin ? pmode_pkg::MODE_MICRO
                                        : pmode_pkg::MODE_SINGLE;
         lock_next    = i_boot_mode_pin;
      end else if (soft_rst || i_watchdog_reset) begin
         pm_next[7:2] = pmode_pkg::PM_RESET[7:2];
      end else if (i_pm_write && i_mode_register_write_enable) begin
         pm_next = i_pm_wdata;
         if (i_pm_wdata[pmode_pkg::SWRST_BIT]) begin
            pm_next[pmode_pkg::SWRST_BIT] = 1'b0;
            rst_next                      = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pm_reg   <= pmode_pkg::PM_RESET;
         lock_reg <= 1'b0;
         boot_reg <= 1'b1;
         rst_reg  <= 1'b0;
      end else begin
         pm_reg   <= pm_next;
         lock_reg <= lock_next;
         boot_reg <= boot_next;
         rst_reg  <= rst_next;
      end
   end

   // Pins, boot vector and decode output
   always_comb begin
      busen_next = bus_mode;
      clk_next   = 1'b0;
      clkoe_next = 1'b0;
      if (bus_mode) begin
         if (!pm_reg[pmode_pkg::BCLK_SEL_BIT]) begin
            clk_next   = i_bus_clock;
            clkoe_next = 1'b1;
         end else if (i_clock_pin_function == pmode_pkg::CLKPIN_PORT) begin
            clk_next   = 1'b0;
            clkoe_next = 1'b1;
         end
      end // Single-chip leaves clock pin to the port
      start_next = start_reg;
      width_next = width_reg;
      if (i_vector_valid) begin
         start_next = {i_reset_vector[31:2], 2'b00};
         width_next = (mode_now == pmode_pkg::MODE_MICRO)
                      ? (i_reset_vector[1:0] & pmode_pkg::WIDTH_MASK)
                      : 2'b00;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         busen_reg <= 1'b0;
         clk_reg   <= 1'b0;
         clkoe_reg <= 1'b0;
         start_reg <= 32'h0000_0000;
         width_reg <= 2'b00;
         dec_reg   <= '0;
      end else begin
         busen_reg <= busen_next;
         clk_reg   <= clk_next;
         clkoe_reg <= clkoe_next;
         start_reg <= start_next;
         width_reg <= width_next;
         dec_reg   <= dec_next;
      end
   end

   assign o_processor_mode_register = pm_reg;
   assign o_mode              = mode_now;
   assign o_rom_lock          = lock_reg;
   assign o_device_reset      = rst_reg;
   assign o_bus_pins_enable   = busen_reg;
   assign o_clock_pin_port    = clk_reg;
   assign o_clock_pin_port_oe = clkoe_reg;
   assign o_start_addr        = start_reg;
   assign o_ext_bus_width     = width_reg;
   assign o_dec               = dec_reg;

   // Assertions: start mode and ROM lock

   boot_strap_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      $fell(boot_reg) |-> (pm_reg[1:0] ==
         ($past(i_boot_mode_pin) ? 2'b11 : 2'b00)))
      else $error("mode after reset does not follow boot pin");
   boot_lock_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      $fell(boot_reg) |-> lock_reg == $past(i_boot_mode_pin))
      else $error("ROM lock does not follow boot pin");
   lock_hold_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      !boot_reg |=> $stable(lock_reg))
      else $error("ROM lock changed outside hardware reset");

   // Assertions: register writes and reset sources

   prot_write_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (!boot_reg && !rst_reg && !i_watchdog_reset && i_pm_write &&
       !i_mode_register_write_enable) |=> $stable(pm_reg))
      else $error("unprotected write changed mode register");
   write_take_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (!boot_reg && !rst_reg && !i_watchdog_reset && i_pm_write &&
       i_mode_register_write_enable)
      |=> pm_reg == ($past(i_pm_wdata) & 8'hf7))
      else $error("enabled write not taken into mode register");
   expand_write_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (!boot_reg && !rst_reg && !i_watchdog_reset && i_pm_write &&
       i_mode_register_write_enable && i_pm_wdata[1:0] == 2'b01)
      |=> o_mode == pmode_pkg::MODE_EXPAND)
      else $error("write 01b did not enter expansion mode");
   swrst_keep_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      rst_reg && !boot_reg |=> pm_reg[1:0] == $past(pm_reg[1:0]))
      else $error("software reset changed processor mode");
   wdt_keep_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_watchdog_reset && !boot_reg
      |=> pm_reg[1:0] == $past(pm_reg[1:0]) && pm_reg[7:2] == 6'h00)
      else $error("watchdog reset changed processor mode");
   swrst_pulse_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      rst_reg |=> !rst_reg && !pm_reg[pmode_pkg::SWRST_BIT])
      else $error("software reset request not a single pulse");
   swrst_req_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (!boot_reg && !rst_reg && !i_watchdog_reset && i_pm_write &&
       i_mode_register_write_enable && i_pm_wdata[pmode_pkg::SWRST_BIT])
      |=> rst_reg)
      else $error("software reset bit did not request a reset");

   // Assertions: pins and clock output

   single_clk_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      mode_now == pmode_pkg::MODE_SINGLE |=> !clkoe_reg)
      else $error("bus clock driven in single-chip mode");
   clk_low_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      bus_mode && pm_reg[pmode_pkg::BCLK_SEL_BIT] &&
      i_clock_pin_function == pmode_pkg::CLKPIN_PORT
      |=> clkoe_reg && !clk_reg)
      else $error("clock pin not held low");
   bus_pins_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      ##1 busen_reg == $past(bus_mode))
      else $error("bus pin enable does not follow mode");
   single_pins_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      mode_now == pmode_pkg::MODE_SINGLE |=> !busen_reg)
      else $error("pins taken for bus in single-chip mode");

   // Assertions: address map

   low_map_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_req.valid && i_req.addr < pmode_pkg::ADDR_RAM
      |=> dec_reg.region == pmode_pkg::REG_PERIPH && dec_reg.hit)
      else $error("peripheral range decoded wrong");
   ram_map_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_req.valid && i_req.addr >= pmode_pkg::ADDR_RAM &&
      i_req.addr < pmode_pkg::ADDR_PERIPH2
      |=> dec_reg.region == pmode_pkg::REG_RAM)
      else $error("internal RAM range decoded wrong");
   drom_map_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_req.valid && i_req.addr >= pmode_pkg::ADDR_DROM &&
      i_req.addr < pmode_pkg::ADDR_DROM_END
      |=> dec_reg.region == pmode_pkg::REG_DATA_ROM && dec_reg.hit)
      else $error("data ROM range decoded wrong");
   ext_low_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_req.valid && i_req.addr >= pmode_pkg::ADDR_EXT_LO &&
      i_req.addr < pmode_pkg::ADDR_UNUSABLE
      |=> dec_reg.hit == $past(bus_mode))
      else $error("low external window wrong");
   unusable_range_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_req.valid && i_req.addr >= pmode_pkg::ADDR_UNUSABLE &&
      i_req.addr < pmode_pkg::ADDR_EXT_HI
      |=> !dec_reg.hit)
      else $error("unusable range decoded");
   top_micro_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_req.valid && i_req.addr >= pmode_pkg::ADDR_TOP_ROM &&
      mode_now == pmode_pkg::MODE_MICRO
      |=> dec_reg.region == pmode_pkg::REG_EXTERNAL)
      else $error("top range not external in micro mode");
   top_rom_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_req.valid && i_req.addr >= pmode_pkg::ADDR_TOP_ROM &&
      mode_now != pmode_pkg::MODE_MICRO && !lock_reg
      |=> dec_reg.region == pmode_pkg::REG_INT_ROM)
      else $error("top range not internal ROM");
   rom_lock_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      lock_reg |=> dec_reg.region != pmode_pkg::REG_INT_ROM)
      else $error("internal ROM reached after micro start");
   micro_space_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      mode_now == pmode_pkg::MODE_MICRO |=> !(dec_reg.region == pmode_pkg::REG_INT_ROM))
      else $error("internal ROM reached in micro mode");

   // Assertions: reset vector

   start_addr_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_vector_valid
      |=> o_start_addr == {$past(i_reset_vector[31:2]), 2'b00})
      else $error("start address not taken from vector");
   bus_width_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_vector_valid && mode_now == pmode_pkg::MODE_MICRO
      |=> o_ext_bus_width == $past(i_reset_vector[1:0]))
      else $error("bus width not taken from vector");
   width_single_a: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_vector_valid && mode_now != pmode_pkg::MODE_MICRO
      |=> o_ext_bus_width == 2'b00)
      else $error("bus width set outside micro mode");

   cover_expand_c: cover property (@(posedge i_clk)
      o_mode == pmode_pkg::MODE_EXPAND);
   cover_micro_c: cover property (@(posedge i_clk)
      o_mode == pmode_pkg::MODE_MICRO && lock_reg);
   cover_swrst_c: cover property (@(posedge i_clk) rst_reg && bus_mode);
   cover_clklow_c: cover property (@(posedge i_clk) clkoe_reg && !clk_reg);
   cover_wdt_c: cover property (@(posedge i_clk) i_watchdog_reset && bus_mode);

endmodule : processor_mode_select
`default_nettype wire

// File: sim/ext_bus_device.sv
`default_nettype none
module ext_bus_device (
   // Clock
   input  wire logic               i_clk,
   // Bus side of the block
   input  wire pmode_pkg::decode_t i_dec,
   input  wire logic               i_bus_pins_enable,
   // Observed traffic
   output var  logic [7:0]         o_hits,
   output var  logic [7:0]         o_stray
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_hits  = 8'h00;
      o_stray = 8'h00;
   end
   // Accept only external cycles; pins must belong to the bus then
   always @(posedge i_clk) begin
      if (i_dec.hit === 1'b1 && i_dec.region === pmode_pkg::REG_EXTERNAL) begin
         o_hits <= o_hits + 8'h01;
         if (i_bus_pins_enable !== 1'b1) begin
            o_stray <= o_stray + 8'h01;
         end
      end
   end
endmodule : ext_bus_device
`default_nettype wire

// File: sim/processor_mode_select_bench.sv
`default_nettype none
module processor_mode_select_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 i_clk = 1'b0;
   logic                 i_reset = 1'b1;
   logic                 i_boot_mode_pin = 1'b0;
   logic                 i_watchdog_reset = 1'b0;
   logic                 i_pm_write = 1'b0;
   logic [7:0]           i_pm_wdata = 8'h00;
   logic                 i_mode_register_write_enable = 1'b0;
   logic [1:0]           i_clock_pin_function = 2'b00;
   logic                 i_vector_valid = 1'b0;
   logic [31:0]          i_reset_vector = 32'h0000_0000;
   pmode_pkg::bus_req_t  i_req = '0;
   logic [7:0]           o_pm_reg;
   pmode_pkg::proc_mode_t o_mode;
   pmode_pkg::decode_t   o_dec;
   logic                 o_rom_lock, o_device_reset, o_bus_pins_enable;
   logic                 o_clock_pin_port, o_clock_pin_port_oe;
   logic [31:0]          o_start_addr;
   logic [1:0]           o_ext_bus_width;
   logic [7:0]           hits, stray;
   logic                 swrst_seen = 1'b0;
   int                   fail_count = 0;
   int                   comparisons = 0;

   always #2 i_clk = ~i_clk;

   processor_mode_select uut (
      .i_clk(i_clk), .i_reset(i_reset), .i_boot_mode_pin(i_boot_mode_pin),
      .i_watchdog_reset(i_watchdog_reset), .i_pm_write(i_pm_write),
      .i_pm_wdata(i_pm_wdata),
      .i_mode_register_write_enable(i_mode_register_write_enable),
      .i_clock_pin_function(i_clock_pin_function), .i_bus_clock(1'b1),
      .i_vector_valid(i_vector_valid), .i_reset_vector(i_reset_vector),
      .i_req(i_req), .o_processor_mode_register(o_pm_reg), .o_mode(o_mode),
      .o_rom_lock(o_rom_lock), .o_device_reset(o_device_reset),
      .o_bus_pins_enable(o_bus_pins_enable),
      .o_clock_pin_port(o_clock_pin_port),
      .o_clock_pin_port_oe(o_clock_pin_port_oe),
      .o_start_addr(o_start_addr), .o_ext_bus_width(o_ext_bus_width),
      .o_dec(o_dec));

   ext_bus_device far_end (
      .i_clk(i_clk), .i_dec(o_dec), .i_bus_pins_enable(o_bus_pins_enable),
      .o_hits(hits), .o_stray(stray));

   // Catch the one-cycle software reset pulse
   always @(posedge i_clk) begin
      if (o_device_reset === 1'b1) swrst_seen <= 1'b1;
   end

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish;
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic hw_reset(input logic pin);
      @(posedge i_clk);
      i_boot_mode_pin <= pin;
      i_reset <= 1'b1;
      repeat (20) @(posedge i_clk);
      i_reset <= 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
   endtask : hw_reset

   task automatic wr(input logic [7:0] d, input logic en);
      @(posedge i_clk);
      i_pm_write <= 1'b1;
      i_pm_wdata <= d;
      i_mode_register_write_enable <= en;
      @(posedge i_clk);
      i_pm_write <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
   endtask : wr

   task automatic dec(input logic [31:0] a, input pmode_pkg::region_t r);
      @(posedge i_clk);
      i_req <= {1'b1, a};
      @(posedge i_clk);
      i_req <= {1'b0, a};
      #1;
      chk("region", 32'(o_dec.region), 32'(r));
   endtask : dec

   initial begin
      #200000;
      fail_count++;
      tally_and_finish();
   end

   initial begin
      hw_reset(1'b0);
      chk("mode", 32'(o_mode), 32'(pmode_pkg::MODE_SINGLE));
      chk("pins", 32'(o_bus_pins_enable), 32'h0);
      chk("clk_oe", 32'(o_clock_pin_port_oe), 32'h0);
      dec(32'h0000_0000, pmode_pkg::REG_PERIPH);
      dec(32'h0000_0400, pmode_pkg::REG_RAM);
      dec(32'h0006_1fff, pmode_pkg::REG_DATA_ROM);
      dec(32'h0200_0000, pmode_pkg::REG_UNUSABLE);
      dec(32'hffe0_0000, pmode_pkg::REG_INT_ROM);
      wr(8'h01, 1'b0);
      chk("mode", 32'(o_mode), 32'(pmode_pkg::MODE_SINGLE));
      wr(8'h01, 1'b1);
      chk("mode", 32'(o_mode), 32'(pmode_pkg::MODE_EXPAND));
      chk("pins", 32'(o_bus_pins_enable), 32'h1);
      dec(32'h0008_0000, pmode_pkg::REG_EXTERNAL);
      dec(32'h01ff_ffff, pmode_pkg::REG_EXTERNAL);
      dec(32'hfdff_ffff, pmode_pkg::REG_UNUSABLE);
      dec(32'hffe0_0000, pmode_pkg::REG_INT_ROM);
      chk("clk_oe", 32'(o_clock_pin_port_oe), 32'h1);
      wr(8'h81, 1'b1);
      chk("reg", 32'(o_pm_reg), 32'h81);
      chk("clk_pin", 32'(o_clock_pin_port), 32'h0);
      chk("clk_oe", 32'(o_clock_pin_port_oe), 32'h1);
      wr(8'h09, 1'b1);
      chk("swrst", 32'(swrst_seen), 32'h1);
      chk("mode", 32'(o_mode), 32'(pmode_pkg::MODE_EXPAND));
      chk("reg_b3", 32'(o_pm_reg[3]), 32'h0);
      chk("reg", 32'(o_pm_reg), 32'h01);
      wr(8'h81, 1'b1);
      @(posedge i_clk);
      i_watchdog_reset <= 1'b1;
      @(posedge i_clk);
      i_watchdog_reset <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      chk("mode", 32'(o_mode), 32'(pmode_pkg::MODE_EXPAND));
      chk("reg", 32'(o_pm_reg), 32'h01);
      hw_reset(1'b1);
      chk("mode", 32'(o_mode), 32'(pmode_pkg::MODE_MICRO));
      chk("lock", 32'(o_rom_lock), 32'h1);
      chk("pins", 32'(o_bus_pins_enable), 32'h1);
      @(posedge i_clk);
      i_vector_valid <= 1'b1;
      i_reset_vector <= 32'h1234_5673;
      @(posedge i_clk);
      i_vector_valid <= 1'b0;
      @(posedge i_clk);
      #1;
      chk("start", o_start_addr, 32'h1234_5670);
      chk("width", 32'(o_ext_bus_width), 32'h3);
      dec(32'hffe0_0000, pmode_pkg::REG_EXTERNAL);
      dec(32'h0006_0000, pmode_pkg::REG_DATA_ROM);
      wr(8'h01, 1'b1);
      chk("mode", 32'(o_mode), 32'(pmode_pkg::MODE_EXPAND));
      dec(32'hffe0_0000, pmode_pkg::REG_NONE);
      chk("rom_hit", 32'(o_dec.hit), 32'h0);
      chk("ext_hits", 32'(hits), 32'h3);
      chk("stray", 32'(stray), 32'h0);
      tally_and_finish();
   end
endmodule : processor_mode_select_bench
`default_nettype wire
